/* tb_two_wire_serial_event_ack_logic.sv */
/*
  tb_two_wire_serial_event_ack_logic: register tasks plus a bus master
  model addressing the core. Assumes pull-ups on both lines.
*/
`timescale 1ns/1ps
module tb_two_wire_serial_event_ack_logic;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, m_scl, m_sda;
  int n_errors = 0;
  int tests_run = 0;
  // wired-and lines with pull-ups
  wire scl = (scl_oe_o ? scl_o : 1'b1) & ~m_scl;
  wire sda = (sda_oe_o ? sda_o : 1'b1) & ~m_sda;
  // system clock
  always #10 sys_clk_i = ~sys_clk_i;
  twsea_core i_twsea_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  twsea_bus_model i_twsea_bus_model (.scl_i(scl), .sda_i(sda),
    .scl_pull_o(m_scl), .sda_pull_o(m_sda));
  task automatic results();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] s, x);
    tests_run++;
    if (s !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, x, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] x);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk($sformatf("reg %0d", a), reg_rdata_o, x);
  endtask
  task automatic wait_irq();
    repeat (2) @(posedge sys_clk_i); // let a just-cleared irq drop
    for (int n = 0; n < 6000 && irq_o !== 1'b1; n++) @(posedge sys_clk_i);
    chk("irq", {7'h0, irq_o}, 8'h01);
    if (irq_o !== 1'b1) results();
  endtask
  // clear event flag and sticky interrupt bits
  task automatic clr(input logic [7:0] ctl);
    wr(twsea_pkg::A_CTRL, ctl);
    wr(twsea_pkg::A_IST, 8'h07);
  endtask
  task automatic addr_case(input logic [7:0] own, ctl, adr,
                           input logic ackx, input logic [7:0] stx, dsx);
    logic a;
    wr(twsea_pkg::A_OWN, own);
    wr(twsea_pkg::A_CTRL, ctl);
    i_twsea_bus_model.start_cond();
    i_twsea_bus_model.send_byte(adr, a);
    chk("addr ack", {7'h0, a}, {7'h0, ackx});
    rdc(twsea_pkg::A_STAT, stx);
    if (stx != 8'hF8) begin
      wait_irq();
      wr(twsea_pkg::A_IMSK, 8'h00);
      rdc(twsea_pkg::A_IMSK, 8'h00);
      chk("masked irq", {7'h0, irq_o}, 8'h00);
      wr(twsea_pkg::A_IMSK, 8'h01);
      rdc(twsea_pkg::A_STAT, stx);
      chk("hold", {7'h0, scl_oe_o}, 8'h01);
      clr(ctl);
      rdc(twsea_pkg::A_STAT, 8'hF8);
      chk("irq off", {7'h0, irq_o}, 8'h00);
      chk("hold off", {7'h0, scl_oe_o}, 8'h00);
      i_twsea_bus_model.send_byte(8'h5A, a);
      chk("data ack", {7'h0, a}, 8'h00);
      wait_irq();
      rdc(twsea_pkg::A_STAT, dsx);
      rdc(twsea_pkg::A_DATA, 8'h5A);
      clr(ctl);
    end else
      chk("no irq", {7'h0, irq_o}, 8'h00);
    i_twsea_bus_model.stop_cond();
    if (stx != 8'hF8) begin
      wait_irq();
      rdc(twsea_pkg::A_STAT, 8'hA0);
      clr(ctl);
    end
    wr(twsea_pkg::A_IST, 8'h07);
    $display("case done own %h addr %h", own, adr);
  endtask
  // main sequence
  initial begin
    logic a;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdc(twsea_pkg::A_STAT, 8'hF8);
    rdc(3'h6, 8'h00);
    wr(twsea_pkg::A_IMSK, 8'h01);
    addr_case(8'h54, 8'h03, 8'h54, 1'b0, 8'h60, 8'h80);
    addr_case(8'h54, 8'h03, 8'h56, 1'b1, 8'hF8, 8'h00);
    addr_case(8'h54, 8'h01, 8'h54, 1'b1, 8'hF8, 8'h00);
    addr_case(8'h55, 8'h03, 8'h00, 1'b0, 8'h70, 8'h90);
    addr_case(8'h55, 8'h01, 8'h00, 1'b1, 8'hF8, 8'h00);
    // selected slave told to recover: lines released, not selected
    wr(twsea_pkg::A_OWN, 8'h54);
    wr(twsea_pkg::A_CTRL, 8'h03);
    i_twsea_bus_model.start_cond();
    i_twsea_bus_model.send_byte(8'h54, a);
    wait_irq();
    clr(8'h07);
    rdc(twsea_pkg::A_CTRL, 8'h03);
    i_twsea_bus_model.send_byte(8'h5A, a);
    chk("released ack", {7'h0, a}, 8'h01);
    rdc(twsea_pkg::A_STAT, 8'hF8);
    i_twsea_bus_model.stop_cond();
    wr(twsea_pkg::A_IST, 8'h07);
    $display("case done slave recover");
    wr(twsea_pkg::A_CTRL, 8'h09);
    wait_irq();
    rdc(twsea_pkg::A_STAT, 8'h08);
    chk("master hold", {7'h0, scl_oe_o}, 8'h01);
    rdc(twsea_pkg::A_CTRL, 8'h11);
    $display("case done master start");
    // address and one data byte as master, nobody acknowledges
    wr(twsea_pkg::A_DATA, 8'hA0);
    clr(8'h01);
    wait_irq();
    rdc(twsea_pkg::A_STAT, 8'h20);
    wr(twsea_pkg::A_DATA, 8'h3C);
    clr(8'h01);
    wait_irq();
    rdc(twsea_pkg::A_STAT, 8'h30);
    clr(8'h05);
    repeat (800) @(posedge sys_clk_i);
    rdc(twsea_pkg::A_CTRL, 8'h01);
    rdc(twsea_pkg::A_IST, 8'h04);
    chk("bus free", {6'h0, scl_oe_o, sda_oe_o}, 8'h00);
    $display("case done master write");
    chk("model stalls", 8'(i_twsea_bus_model.stalls), 8'h00);
    results();
  end
  // hang guard
  initial begin
    #1ms;
    n_errors++;
    results();
  end
endmodule

/* twsea_bus_model.sv */
/*
  twsea_bus_model: behavioural bus master on the far side of the link.
  Assumes pull-ups on both lines, resolved in the bench.
*/
`timescale 1ns/1ps
module twsea_bus_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  localparam int HALF = 80;
  int stalls = 0;
  // both lines released at start
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  // release clock, wait while stretched, then one high phase
  task automatic rise();
    scl_pull_o = 1'b0;
    for (int n = 0; n < 5000 && scl_i !== 1'b1; n++) #20;
    if (scl_i !== 1'b1)
      stalls++; // checked by the bench
    #HALF;
  endtask
  // data falls while clock high
  task automatic start_cond();
    sda_pull_o = 1'b1;
    #HALF;
    scl_pull_o = 1'b1;
  endtask
  // msb first, then one ack clock; ack is the line level
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      #(HALF / 2);
      sda_pull_o = (i > 0) ? ~b[i - 1] : 1'b0;
      #(HALF / 2);
      rise();
      ack = sda_i;
      scl_pull_o = 1'b1;
    end
    #300;
  endtask
  // data rises while clock high
  task automatic stop_cond();
    #(HALF / 2);
    sda_pull_o = 1'b1;
    #(HALF / 2);
    rise();
    sda_pull_o = 1'b0;
    #HALF;
  endtask
endmodule

/* twsea_core.sv */
/*
  twsea_core: byte-level two-wire bus interface with serial event
  flag, clock hold, acknowledge control and master sequencer.
  Assumes open-drain pins resolved outside, an 8-bit register port
  with read data one cycle after the read strobe.
*/
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module twsea_core (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o
);
  logic scl_m1_q, scl_m2_q, scl_p_q;
  logic sda_m1_q, sda_m2_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic en_q, ack_q, sto_q, sta_q;
  logic [7:0] own_q;
  logic [2:0] imsk_q, ist_q, ist_set, ist_clr;
  logic si_p_q, irq_q;
  logic [7:0] rdata_q, rd_val;
  logic si_q, busy_q, hold_q;
  logic [4:0] code_q;
  logic [7:0] data_q, shift_q;
  logic [3:0] bit_q;
  logic addr_ph_q, sel_q, mst_q, tx_q, arb_q;
  logic gc_q, hit_q, rx_ack_q, sda_low_q;
  twsea_pkg::twsea_mst_t st_q;
  logic [8:0] tm_q;
  logic scl_m_low_q, rs_q, rise_q;
  logic wr_ctrl, si_clr, tm_done, gen_start, own_start;
  logic start_ext, slave_rec, preempt, active;
  logic bit_fall, ack_begin, byte_end, fsm_sda_low, fsm_sda_rel;
  logic [1:0] addr_m;

  // address compare: bit 1 general call hit, bit 0 own address hit
  function automatic logic [1:0] addr_match(input logic [7:0] rx_b,
                                            input logic [7:0] own);
    logic [1:0] m;
    m[0] = (rx_b[7:1] == own[7:1]);
    m[1] = (rx_b == twsea_pkg::BYTE_RST) & own[twsea_pkg::O_GC];
    return m;
  endfunction

  // two-stage synchronisers plus one stage for edge detection
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_m1_q <= 1'b1;
      scl_m2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m1_q <= 1'b1;
      sda_m2_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m1_q <= scl_i;
      scl_m2_q <= scl_m1_q;
      scl_p_q <= scl_m2_q;
      sda_m1_q <= sda_i;
      sda_m2_q <= sda_m1_q;
      sda_p_q <= sda_m2_q;
    end
  end

  // bus edges and conditions
  assign scl_rise = scl_m2_q & ~scl_p_q;
  assign scl_fall = ~scl_m2_q & scl_p_q;
  assign start_det = scl_m2_q & scl_p_q & sda_p_q & ~sda_m2_q;
  assign stop_det = scl_m2_q & scl_p_q & ~sda_p_q & sda_m2_q;

  // decode and sequencing terms
  assign wr_ctrl = reg_wr_i & (reg_addr_i == twsea_pkg::A_CTRL);
  assign si_clr = si_q & wr_ctrl & ~reg_wdata_i[twsea_pkg::C_SI];
  assign tm_done = (tm_q == twsea_pkg::HALF_LAST);
  assign own_start = (st_q == twsea_pkg::M_STA);
  assign gen_start = own_start & tm_done;
  assign start_ext = start_det & ~own_start;
  assign slave_rec = sto_q & ~mst_q & (st_q == twsea_pkg::M_IDLE);
  assign preempt = ~en_q | gen_start | start_ext | stop_det | slave_rec;
  assign active = addr_ph_q | sel_q | mst_q | arb_q;
  assign bit_fall = scl_fall & active & ~preempt;
  assign ack_begin = bit_fall & (bit_q == twsea_pkg::LAST_BIT);
  assign byte_end = bit_fall & (bit_q == twsea_pkg::ACK_BIT);
  assign addr_m = addr_match(shift_q, own_q);

  // control, own address and mask registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      ack_q <= 1'b0;
      sto_q <= 1'b0;
      sta_q <= 1'b0;
      own_q <= twsea_pkg::BYTE_RST;
      imsk_q <= twsea_pkg::IRQ_RST;
    end else begin
      if (wr_ctrl) begin
        en_q <= reg_wdata_i[twsea_pkg::C_EN];
        ack_q <= reg_wdata_i[twsea_pkg::C_ACK];
        sto_q <= reg_wdata_i[twsea_pkg::C_STO];
        sta_q <= reg_wdata_i[twsea_pkg::C_STA];
      end
      if (reg_wr_i && reg_addr_i == twsea_pkg::A_OWN)
        own_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == twsea_pkg::A_IMSK)
        imsk_q <= reg_wdata_i[2:0];
      // hardware clears win over a software write
      if (gen_start)
        sta_q <= 1'b0;
      if (stop_det | slave_rec)
        sto_q <= 1'b0;
    end
  end

  // bus busy between a START and a STOP
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
    end
  end

  // a bit ends at the first fall after its rise; the fall that follows
  // a START carries no bit and must not be counted
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_q <= 1'b0;
    end else if (gen_start | start_ext | stop_det | bit_fall) begin
      rise_q <= 1'b0;
    end else if (scl_rise & active) begin
      rise_q <= 1'b1;
    end
  end

  // clock hold: engages once the line is already low
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= en_q & si_q & (hold_q | ~scl_m2_q);
    end
  end

  // master sequencer: START, clocking, STOP and repeated START
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= twsea_pkg::M_IDLE;
      tm_q <= twsea_pkg::TM_RST;
      scl_m_low_q <= 1'b0;
      rs_q <= 1'b0;
    end else begin
      case (st_q)
        twsea_pkg::M_IDLE: begin
          scl_m_low_q <= 1'b0;
          tm_q <= twsea_pkg::TM_RST;
          if (en_q & sta_q & ~busy_q) begin
            st_q <= twsea_pkg::M_STA;
            rs_q <= 1'b0;
          end
        end
        twsea_pkg::M_STA: begin
          tm_q <= tm_q + 9'h001;
          if (tm_done) begin
            scl_m_low_q <= 1'b1;
            tm_q <= twsea_pkg::TM_RST;
            st_q <= twsea_pkg::M_RUN;
          end
        end
        twsea_pkg::M_RUN: begin
          if (~mst_q | ~en_q) begin
            st_q <= twsea_pkg::M_IDLE;
            scl_m_low_q <= 1'b0;
          end else if (scl_m_low_q) begin
            if (~tm_done) begin
              tm_q <= tm_q + 9'h001;
            end else if (~si_q) begin
              tm_q <= twsea_pkg::TM_RST;
              if (bit_q == twsea_pkg::BIT_RST && sto_q)
                st_q <= twsea_pkg::M_STOA;
              else if (bit_q == twsea_pkg::BIT_RST && sta_q)
                st_q <= twsea_pkg::M_RSA;
              else
                scl_m_low_q <= 1'b0;
            end
          end else if (~scl_m2_q) begin
            tm_q <= twsea_pkg::TM_RST; // stretched by a slave
          end else if (tm_done) begin
            scl_m_low_q <= 1'b1;
            tm_q <= twsea_pkg::TM_RST;
          end else begin
            tm_q <= tm_q + 9'h001;
          end
        end
        twsea_pkg::M_STOA, twsea_pkg::M_RSA: begin
          tm_q <= tm_q + 9'h001;
          if (tm_done) begin
            scl_m_low_q <= 1'b0;
            tm_q <= twsea_pkg::TM_RST;
            st_q <= (st_q == twsea_pkg::M_STOA) ? twsea_pkg::M_STOB
                                                 : twsea_pkg::M_RSB;
          end
        end
        twsea_pkg::M_STOB, twsea_pkg::M_RSB: begin
          if (~scl_m2_q) begin
            tm_q <= twsea_pkg::TM_RST;
          end else if (tm_done) begin
            tm_q <= twsea_pkg::TM_RST;
            rs_q <= (st_q == twsea_pkg::M_RSB);
            st_q <= (st_q == twsea_pkg::M_STOB) ? twsea_pkg::M_STOC
                                                 : twsea_pkg::M_STA;
          end else begin
            tm_q <= tm_q + 9'h001;
          end
        end
        twsea_pkg::M_STOC: begin
          tm_q <= tm_q + 9'h001; // bus free time
          if (tm_done)
            st_q <= twsea_pkg::M_IDLE;
        end
        default: begin
          st_q <= twsea_pkg::M_IDLE;
          scl_m_low_q <= 1'b0;
        end
      endcase
    end
  end

  // sequencer drive of the data line
  assign fsm_sda_low = (st_q == twsea_pkg::M_STA) |
                       (st_q == twsea_pkg::M_STOA) |
                       (st_q == twsea_pkg::M_STOB);
  assign fsm_sda_rel = (st_q == twsea_pkg::M_RSA) |
                       (st_q == twsea_pkg::M_RSB) |
                       (st_q == twsea_pkg::M_STOC); // stale bit no block

  // byte engine: shifting, acknowledge, event flag and status code
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      si_q <= 1'b0;
      code_q <= twsea_pkg::S_IDLE;
      data_q <= twsea_pkg::BYTE_RST;
      shift_q <= twsea_pkg::BYTE_RST;
      bit_q <= twsea_pkg::BIT_RST;
      addr_ph_q <= 1'b0;
      sel_q <= 1'b0;
      mst_q <= 1'b0;
      tx_q <= 1'b0;
      arb_q <= 1'b0;
      gc_q <= 1'b0;
      hit_q <= 1'b0;
      rx_ack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == twsea_pkg::A_DATA)
        data_q <= reg_wdata_i;
      // software clear resumes the transfer; any set below wins
      if (si_clr) begin
        si_q <= 1'b0;
        code_q <= twsea_pkg::S_IDLE;
        if (tx_q) begin
          shift_q <= data_q;
          sda_low_q <= ~data_q[7];
        end
      end
      if (~en_q) begin
        addr_ph_q <= 1'b0;
        sel_q <= 1'b0;
        mst_q <= 1'b0;
        tx_q <= 1'b0;
        arb_q <= 1'b0;
        sda_low_q <= 1'b0;
        bit_q <= twsea_pkg::BIT_RST;
      end else if (gen_start) begin
        mst_q <= 1'b1;
        tx_q <= 1'b1;
        addr_ph_q <= 1'b1;
        sel_q <= 1'b0;
        bit_q <= twsea_pkg::BIT_RST;
        sda_low_q <= 1'b1;
        si_q <= 1'b1;
        code_q <= rs_q ? twsea_pkg::S_RSTART : twsea_pkg::S_START;
      end else if (start_ext | stop_det) begin
        if (sel_q) begin
          si_q <= 1'b1;
          code_q <= twsea_pkg::S_STOP;
        end
        addr_ph_q <= start_ext;
        sel_q <= 1'b0;
        mst_q <= 1'b0;
        tx_q <= 1'b0;
        arb_q <= 1'b0;
        sda_low_q <= 1'b0;
        bit_q <= twsea_pkg::BIT_RST;
      end else if (slave_rec) begin
        addr_ph_q <= 1'b0;
        sel_q <= 1'b0;
        tx_q <= 1'b0;
        sda_low_q <= 1'b0;
        bit_q <= twsea_pkg::BIT_RST;
      end else if (scl_rise & active) begin
        if (bit_q != twsea_pkg::ACK_BIT) begin
          shift_q <= {shift_q[6:0], sda_m2_q};
          if (mst_q & tx_q & ~sda_low_q & ~sda_m2_q & ~fsm_sda_low) begin
            arb_q <= 1'b1;
            mst_q <= 1'b0;
            tx_q <= 1'b0;
          end
        end else begin
          rx_ack_q <= ~sda_m2_q;
        end
      end else if (ack_begin) begin
        bit_q <= twsea_pkg::ACK_BIT;
        if (tx_q | arb_q) begin
          sda_low_q <= 1'b0;
        end else if (addr_ph_q & ~mst_q) begin
          hit_q <= ack_q & (|addr_m);
          gc_q <= ack_q & addr_m[1] & ~addr_m[0];
          sda_low_q <= ack_q & (|addr_m);
        end else begin
          sda_low_q <= ack_q;
        end
      end else if (byte_end) begin
        bit_q <= twsea_pkg::BIT_RST;
        sda_low_q <= 1'b0;
        if (arb_q) begin
          arb_q <= 1'b0;
          addr_ph_q <= 1'b0;
          si_q <= 1'b1;
          code_q <= twsea_pkg::S_ARB;
        end else if (mst_q & addr_ph_q) begin
          addr_ph_q <= 1'b0;
          tx_q <= ~shift_q[0];
          si_q <= 1'b1;
          if (shift_q[0])
            code_q <= rx_ack_q ? twsea_pkg::S_MR_SLA_ACK
                               : twsea_pkg::S_MR_SLA_NAK;
          else
            code_q <= rx_ack_q ? twsea_pkg::S_MT_SLA_ACK
                               : twsea_pkg::S_MT_SLA_NAK;
        end else if (mst_q) begin
          si_q <= 1'b1;
          if (~tx_q)
            data_q <= shift_q;
          if (tx_q)
            code_q <= rx_ack_q ? twsea_pkg::S_MT_DAT_ACK
                               : twsea_pkg::S_MT_DAT_NAK;
          else
            code_q <= rx_ack_q ? twsea_pkg::S_MR_DAT_ACK
                               : twsea_pkg::S_MR_DAT_NAK;
        end else if (addr_ph_q) begin
          addr_ph_q <= 1'b0;
          sel_q <= hit_q;
          tx_q <= hit_q & shift_q[0];
          if (hit_q) begin
            si_q <= 1'b1;
            code_q <= gc_q ? twsea_pkg::S_SR_GC :
                      shift_q[0] ? twsea_pkg::S_ST_SLA :
                      twsea_pkg::S_SR_SLA;
          end
        end else if (sel_q) begin
          si_q <= 1'b1;
          if (~tx_q)
            data_q <= shift_q;
          if (tx_q)
            code_q <= rx_ack_q ? twsea_pkg::S_ST_DAT_ACK
                               : twsea_pkg::S_ST_DAT_NAK;
          else if (gc_q)
            code_q <= rx_ack_q ? twsea_pkg::S_GC_DAT_ACK
                               : twsea_pkg::S_GC_DAT_NAK;
          else
            code_q <= rx_ack_q ? twsea_pkg::S_SR_DAT_ACK
                               : twsea_pkg::S_SR_DAT_NAK;
        end
      end else if (bit_fall & rise_q) begin
        bit_q <= bit_q + 4'h1; // next data bit
        if (tx_q)
          sda_low_q <= ~shift_q[7];
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  assign ist_set = {stop_det & busy_q,
                    si_q & ~si_p_q & (code_q == twsea_pkg::S_ARB),
                    si_q & ~si_p_q};
  assign ist_clr = (reg_wr_i && reg_addr_i == twsea_pkg::A_IST) ?
                   reg_wdata_i[2:0] : twsea_pkg::IRQ_RST;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ist_q <= twsea_pkg::IRQ_RST;
      si_p_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      si_p_q <= si_q;
      ist_q <= (ist_q & ~ist_clr) | ist_set;
      irq_q <= |(ist_q & imsk_q);
    end
  end

  // read mux
  always_comb begin
    rd_val = twsea_pkg::BYTE_RST;
    case (reg_addr_i)
      twsea_pkg::A_CTRL: rd_val = {3'h0, si_q, sta_q, sto_q, ack_q, en_q};
      twsea_pkg::A_OWN: rd_val = own_q;
      twsea_pkg::A_DATA: rd_val = data_q;
      twsea_pkg::A_STAT: rd_val = {code_q, 3'h0};
      twsea_pkg::A_IST: rd_val = {5'h00, ist_q};
      twsea_pkg::A_IMSK: rd_val = {5'h00, imsk_q};
      default: rd_val = twsea_pkg::BYTE_RST;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= twsea_pkg::BYTE_RST;
    end else begin
      rdata_q <= reg_rd_i ? rd_val : twsea_pkg::BYTE_RST;
    end
  end

  // pin and output drive
  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_m_low_q | hold_q;
  assign sda_oe_o = fsm_sda_low | (sda_low_q & ~fsm_sda_rel);

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_hold_scl_low: assert property (
    (si_q && en_q && !scl_m2_q && !wr_ctrl) |=> scl_oe_o [*2]
  ) else $error("clock not held while event flag set");
  a_flag_sw_clear: assert property (
    $fell(si_q) |-> $past(si_clr)
  ) else $error("event flag cleared without software write");
  a_start_event: assert property (
    gen_start |=> si_q && (code_q == twsea_pkg::S_START ||
                           code_q == twsea_pkg::S_RSTART)
  ) else $error("generated start raised no event");
  a_own_addr_ack: assert property (
    (ack_begin && addr_ph_q && !mst_q && !tx_q && !arb_q && ack_q &&
     addr_m[0]) |=> sda_oe_o
  ) else $error("own address not acknowledged");
  a_gc_event: assert property (
    (ack_begin && addr_ph_q && !mst_q && !arb_q && ack_q &&
     addr_m == 2'h2) ##1 (!preempt && !scl_fall) [*1] |=>
    (gc_q && hit_q)
  ) else $error("general call not recognised");
  a_no_ack_off: assert property (
    (ack_begin && !ack_q) |=> !sda_low_q
  ) else $error("acknowledge driven while disabled");
  a_data_ack_on: assert property (
    (ack_begin && ack_q && !tx_q && !arb_q && !addr_ph_q &&
     (mst_q || sel_q)) |=> sda_low_q
  ) else $error("received data byte not acknowledged");
  a_addr_no_event: assert property (
    (byte_end && addr_ph_q && !mst_q && !arb_q && !hit_q && !si_q)
    |=> !si_q
  ) else $error("event on unacknowledged address");
  a_addr_event: assert property (
    (byte_end && addr_ph_q && !mst_q && !arb_q && hit_q) |=>
    (si_q && sel_q && code_q != twsea_pkg::S_IDLE)
  ) else $error("own address raised no event");
  a_byte_event: assert property (
    (byte_end && !addr_ph_q && (sel_q || mst_q || arb_q)) |=> si_q
  ) else $error("data byte raised no event");
  a_slave_stop: assert property (
    (stop_det && sel_q && en_q) |=> si_q &&
    code_q == twsea_pkg::S_STOP
  ) else $error("stop as selected slave raised no event");
  a_start_request: assert property (
    (st_q == twsea_pkg::M_IDLE && en_q && sta_q && !busy_q) |=>
    (st_q == twsea_pkg::M_STA) ##1 sda_oe_o
  ) else $error("start request not served on free bus");
  a_slave_recover: assert property (
    slave_rec |=> (!sel_q && !sto_q && !sda_low_q)
  ) else $error("stop request did not release slave");
  a_status_code: assert property (
    $rose(si_q) |-> code_q != twsea_pkg::S_IDLE
  ) else $error("event flag set with idle status code");

  c_master_start: cover property (gen_start ##1 si_q);
  c_slave_hit: cover property (byte_end && addr_ph_q && hit_q);
  c_arb_lost: cover property (byte_end && arb_q);
  c_slave_stop: cover property (stop_det && sel_q);
endmodule

/* twsea_pkg.sv */
/*
  twsea_pkg: constants, register map, status codes and state
  encodings of the two-wire serial event and acknowledge logic.
  Assumes a 50 MHz system clock and an 8-bit register port.
*/
package twsea_pkg;
  // timing: one half period of the generated bus clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC =
    (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] HALF_LAST = 9'(SCL_HALF_CYC - 1);
  localparam logic [8:0] TM_RST = 9'h000;
  // register offsets
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_OWN = 3'h1;
  localparam logic [2:0] A_DATA = 3'h2;
  localparam logic [2:0] A_STAT = 3'h3;
  localparam logic [2:0] A_IST = 3'h4;
  localparam logic [2:0] A_IMSK = 3'h5;
  // control register bit positions
  localparam int C_EN = 0;
  localparam int C_ACK = 1;
  localparam int C_STO = 2;
  localparam int C_STA = 3;
  localparam int C_SI = 4;
  // own address register: general call enable in bit 0
  localparam int O_GC = 0;
  // interrupt status and mask bit positions
  localparam int I_EV = 0;
  localparam int I_ARB = 1;
  localparam int I_STOP = 2;
  // values after reset, plus last data bit and acknowledge bit counts
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // status codes, shown in bits 7:3 of the status register
  localparam logic [4:0] S_START = 5'h01;
  localparam logic [4:0] S_RSTART = 5'h02;
  localparam logic [4:0] S_MT_SLA_ACK = 5'h03;
  localparam logic [4:0] S_MT_SLA_NAK = 5'h04;
  localparam logic [4:0] S_MT_DAT_ACK = 5'h05;
  localparam logic [4:0] S_MT_DAT_NAK = 5'h06;
  localparam logic [4:0] S_ARB = 5'h07;
  localparam logic [4:0] S_MR_SLA_ACK = 5'h08;
  localparam logic [4:0] S_MR_SLA_NAK = 5'h09;
  localparam logic [4:0] S_MR_DAT_ACK = 5'h0A;
  localparam logic [4:0] S_MR_DAT_NAK = 5'h0B;
  localparam logic [4:0] S_SR_SLA = 5'h0C;
  localparam logic [4:0] S_SR_GC = 5'h0E;
  localparam logic [4:0] S_SR_DAT_ACK = 5'h10;
  localparam logic [4:0] S_SR_DAT_NAK = 5'h11;
  localparam logic [4:0] S_GC_DAT_ACK = 5'h12;
  localparam logic [4:0] S_GC_DAT_NAK = 5'h13;
  localparam logic [4:0] S_STOP = 5'h14;
  localparam logic [4:0] S_ST_SLA = 5'h15;
  localparam logic [4:0] S_ST_DAT_ACK = 5'h17;
  localparam logic [4:0] S_ST_DAT_NAK = 5'h18;
  localparam logic [4:0] S_IDLE = 5'h1F;
  // master sequencer states
  typedef enum logic [7:0] {
    M_IDLE = 8'h01,
    M_STA = 8'h02,
    M_RUN = 8'h04,
    M_STOA = 8'h08,
    M_STOB = 8'h10,
    M_STOC = 8'h20,
    M_RSA = 8'h40,
    M_RSB = 8'h80
  } twsea_mst_t;
endpackage
